//--- hdl/psp_cfg.svh
// parallel slave port constants and operation summary
//
// Operation
// - enable bit turns data port into slave
// - control pins become read, write, select
// - control pin directions must be input
// - write spans select and write both low
// - write end latches data, sets flags
// - read start drives latch, sets output flag
// - firmware write mid-read shows, no flag
// - read end releases pins, sets irq flag
// - firmware waits irq flag, polls flags
// - works only in internal memory mode
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH
// ----------------------------------------
// widths, sizes, reset values and the all-input direction value
// ----------------------------------------
`define PSP_DATA_W      8
`define PSP_DIR_ALL_IN  3'h7
`define PSP_LATCH_RST   8'h00
`define PSP_FIFO_DEPTH  16
`define PSP_FIFO_AW     4
`endif

//--- hdl/psp_pkg.sv
// parallel slave port types
`include "psp_cfg.svh"
package psp_pkg;
  // strobe set from the external master, all active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } psp_strb_t;
  // firmware status flags
  typedef struct packed {
    logic in_full;   // byte written by the master, not yet read by firmware
    logic out_full;  // latch handed to the master by a read start
    logic irq;       // a cycle has closed
  } psp_flags_t;
  typedef enum logic [1:0] {PSP_IDLE, PSP_WRITE, PSP_READ} psp_state_t;
endpackage : psp_pkg

//--- hdl/psp_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module psp_fifo #(
  parameter int W  = 8,
  parameter int D  = 16,
  parameter int AW = 4
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] mem_ff [D];     // storage array
  logic [AW:0]  wr_ptr_ff;      // write pointer with wrap bit
  logic [AW:0]  rd_ptr_ff;      // read pointer with wrap bit
  logic         push;
  logic         pop;
  logic         full;
  logic         empty;
  // ----------------------------------------
  // status
  // ----------------------------------------
  assign full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign push  = ce_i && in_valid_i && !full;
  assign pop   = ce_i && out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];
  // storage write, no reset needed for data
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end
  // pointers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule : psp_fifo

//--- hdl/psp_top.sv
// parallel slave port device-side logic
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_top
  import psp_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  input  wire logic                   slave_port_enable_i,   // mode bit
  input  wire logic                   micro_mode_i,          // internal-memory mode
  input  wire logic [2:0]             control_pin_direction_i,
  input  wire psp_strb_t              strb_i,                // raw pins
  input  wire logic [`PSP_DATA_W-1:0] pd_in_i,               // data pins in
  output logic [`PSP_DATA_W-1:0]      pd_out_o,
  output logic                        pd_oe_o,
  input  wire logic                   fw_wr_i,               // firmware latch write
  input  wire logic [`PSP_DATA_W-1:0] fw_wdata_i,
  input  wire logic                   fw_rd_i,               // firmware latch read
  output logic [`PSP_DATA_W-1:0]      fw_rdata_o,
  input  wire logic                   fw_out_full_clr_i,     // output flag clear
  input  wire logic                   fw_irq_clr_i,
  output psp_flags_t                  flags_o,
  output logic                        active_o,
  output logic [`PSP_DATA_W-1:0]      rx_data_o,             // fifo drain side
  output logic                        rx_valid_o,
  input  wire logic                   rx_ready_i
);
  // ----------------------------------------
  // synchroniser and gating
  // ----------------------------------------
  psp_strb_t              s1_ff;     // first stage, read only by s2
  psp_strb_t              s2_ff;     // synchronised strobes
  logic [`PSP_DATA_W-1:0] d1_ff;     // data pins, first stage, read only by d2
  logic [`PSP_DATA_W-1:0] d2_ff;     // data pins, same lag as s2
  psp_state_t             st_ff;     // cycle state
  logic [`PSP_DATA_W-1:0] latch_ff;  // port latch shared by both sides
  logic [`PSP_DATA_W-1:0] din_ff;    // data pins captured while writing
  psp_flags_t             fl_ff;     // firmware flags
  logic                   oe_ff;     // pin drive enable
  logic                   act_ff;    // enable status copy
  logic [`PSP_DATA_W-1:0] rdat_ff;   // firmware read data
  // port enable and decode of the synchronised strobes
  logic                   en;        // port allowed to run
  logic                   wr_go;     // select and write both low
  logic                   rd_go;     // select and read both low
  logic                   wr_end;    // select or write high
  logic                   rd_end;    // select or read high
  // receive queue drain side
  logic [`PSP_DATA_W-1:0] f_data;    // head of queue
  logic                   f_valid;   // queue not empty

  // strobes and data through two flops before any decode; the data pipe
  // keeps the same lag, so the byte kept is the one present at the strobe's
  // rise; the master must hold its data until that rise
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_ff <= '1;
      s2_ff <= '1;
      d1_ff <= `PSP_LATCH_RST;
      d2_ff <= `PSP_LATCH_RST;
    end else if (ce_i) begin
      s1_ff <= strb_i;
      s2_ff <= s1_ff;
      d1_ff <= pd_in_i;
      d2_ff <= d1_ff;
    end
  end

  // port only runs with mode bit, inputs directed, internal memory mode
  assign en = slave_port_enable_i && micro_mode_i
           && (control_pin_direction_i == `PSP_DIR_ALL_IN);
  assign wr_go  = !s2_ff.cs_n && !s2_ff.wr_n;
  assign rd_go  = !s2_ff.cs_n && !s2_ff.rd_n;
  assign wr_end = s2_ff.cs_n || s2_ff.wr_n;
  assign rd_end = s2_ff.cs_n || s2_ff.rd_n;

  // ----------------------------------------
  // cycle state machine
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_ff <= PSP_IDLE;
    end else if (ce_i) begin
      case (st_ff)
        PSP_IDLE: begin
          if (!en) st_ff <= PSP_IDLE;
          else if (wr_go) st_ff <= PSP_WRITE;
          else if (rd_go) st_ff <= PSP_READ;
        end
        PSP_WRITE: if (wr_end) st_ff <= PSP_IDLE;
        PSP_READ:  if (rd_end) st_ff <= PSP_IDLE;
        default:   st_ff <= PSP_IDLE;
      endcase
    end
  end

  // delayed data pins sampled during write; the last sample before the
  // synchronised end is the byte present when the strobe rose
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      din_ff <= `PSP_LATCH_RST;
    end else if (ce_i && st_ff == PSP_WRITE && !wr_end) begin
      din_ff <= d2_ff;
    end
  end

  // port latch: external write end or firmware write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_ff <= `PSP_LATCH_RST;
    end else if (ce_i) begin
      if (st_ff == PSP_WRITE && wr_end) latch_ff <= din_ff;
      else if (fw_wr_i) latch_ff <= fw_wdata_i;
    end
  end

  // drive pins during read; firmware write shows at once
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      oe_ff    <= 1'b0;
      pd_out_o <= `PSP_LATCH_RST;
    end else if (ce_i) begin
      oe_ff    <= (st_ff == PSP_READ) && !rd_end;
      pd_out_o <= fw_wr_i ? fw_wdata_i : latch_ff;
    end
  end

  // ----------------------------------------
  // flags: set wins over clear
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fl_ff <= '0;
    end else if (ce_i) begin
      if (st_ff == PSP_WRITE && wr_end) fl_ff.in_full <= 1'b1;
      else if (fw_rd_i) fl_ff.in_full <= 1'b0;
      // output flag set only on read start, not by mid-read firmware writes
      if (st_ff == PSP_IDLE && en && !wr_go && rd_go) fl_ff.out_full <= 1'b1;
      else if (fw_out_full_clr_i) fl_ff.out_full <= 1'b0;
      if ((st_ff == PSP_WRITE && wr_end) || (st_ff == PSP_READ && rd_end)) begin
        fl_ff.irq <= 1'b1;
      end else if (fw_irq_clr_i) begin
        fl_ff.irq <= 1'b0;
      end
    end
  end

  // firmware read data and activity
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdat_ff <= `PSP_LATCH_RST;
      act_ff  <= 1'b0;
    end else if (ce_i) begin
      rdat_ff <= latch_ff;
      act_ff  <= en;
    end
  end

  // every received byte is also queued; a full fifo drops the byte, so its
  // input ready is left open rather than stalling the external master
  psp_fifo #(.W(`PSP_DATA_W), .D(`PSP_FIFO_DEPTH), .AW(`PSP_FIFO_AW)) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (din_ff),
    .in_valid_i  (st_ff == PSP_WRITE && wr_end),
    .in_ready_o  (),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (rx_ready_i)
  );

  // ports straight from their flops; the queue side comes from the fifo
  assign pd_oe_o    = oe_ff;
  assign flags_o    = fl_ff;
  assign active_o   = act_ff;
  assign fw_rdata_o = rdat_ff;
  assign rx_data_o  = f_data;
  assign rx_valid_o = f_valid;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_wr_close;
    st_ff == PSP_WRITE && wr_end && ce_i;
  endsequence
  property p_wr_flags;
    @(posedge core_clk_i) disable iff (rst_i) s_wr_close |=> fl_ff.in_full && fl_ff.irq;
  endproperty
  a_wr_flags: assert property (p_wr_flags) else $error("write end flags missing");
  property p_rd_release;
    @(posedge core_clk_i) disable iff (rst_i)
      (st_ff == PSP_READ && rd_end && ce_i) |=> !oe_ff && fl_ff.irq;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("read end bad");
  property p_no_drive_off;
    @(posedge core_clk_i) disable iff (rst_i) (!en && st_ff == PSP_IDLE) |=> !oe_ff;
  endproperty
  a_no_drive_off: assert property (p_no_drive_off) else $error("driving while off");

  // read opening: output flag up and state in read one edge later
  sequence s_rd_open;
    st_ff == PSP_IDLE && en && !wr_go && rd_go && ce_i;
  endsequence
  property p_rd_start;
    @(posedge core_clk_i) disable iff (rst_i)
      s_rd_open |=> fl_ff.out_full && st_ff == PSP_READ;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start flag missing");

  // firmware write reaches the pins on the next edge
  property p_fw_show;
    @(posedge core_clk_i) disable iff (rst_i)
      (fw_wr_i && ce_i) |=> pd_out_o == $past(fw_wdata_i);
  endproperty
  a_fw_show: assert property (p_fw_show) else $error("firmware data not shown");

  // firmware read clears the input flag unless a write closes in that cycle
  property p_in_full_clr;
    @(posedge core_clk_i) disable iff (rst_i)
      (fw_rd_i && ce_i && !(st_ff == PSP_WRITE && wr_end)) |=> !fl_ff.in_full;
  endproperty
  a_in_full_clr: assert property (p_in_full_clr) else $error("input flag not cleared");

  // a disabled port never opens a cycle
  property p_idle_off;
    @(posedge core_clk_i) disable iff (rst_i)
      (!en && st_ff == PSP_IDLE && ce_i) |=> st_ff == PSP_IDLE;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("cycle opened while off");
endmodule : psp_top

//--- bench/psp_master.sv
// external eight-bit bus master model
`timescale 1ns/1ps
module psp_master
  import psp_pkg::*;
(
  input  wire logic       clk_i,
  output psp_strb_t       strb_o,
  output logic [7:0]      data_o,
  input  wire logic       oe_i,
  input  wire logic [7:0] data_i
);
  // -------------------------
  // bus cycles
  // -------------------------
  initial begin
    strb_o = 3'h7;
    data_o = 8'h00;
  end
  // one latch write, held long enough for the synchroniser
  task automatic wr(input logic [7:0] b);
    @(posedge clk_i);
    strb_o <= 3'h2;
    data_o <= b;
    repeat (6) @(posedge clk_i);
    strb_o <= 3'h7;
    data_o <= ~b; // released bus, not the last value
  endtask : wr
  // one latch read, data taken while the port drives
  task automatic rd(output logic [7:0] b);
    @(posedge clk_i);
    strb_o <= 3'h1;
    repeat (8) @(posedge clk_i);
    b = oe_i ? data_i : 8'hXX;
    strb_o <= 3'h7;
  endtask : rd
endmodule : psp_master

//--- bench/tb.sv
// testbench for the slave port
`timescale 1ns/1ps
`include "psp_cfg.svh"
module tb;
  import psp_pkg::*;
  logic       core_clk_i, rst_i, en, dir_ok, micro, ce; // clock, reset, mode controls
  logic       fw_wr, fw_rd, of_clr, irq_clr, rdy;       // firmware pulses, drain ready
  logic [7:0] pd_in, pd_out, fw_wd, fw_rd_d, rx_d, b, got;
  logic       pd_oe, active, rx_v;
  psp_strb_t  strb;
  psp_flags_t flags;
  int         err_count, check_count, cyc, seed;
  logic [7:0] q[$]; // bytes the master has written
  psp_master m (.clk_i(core_clk_i), .strb_o(strb), .data_o(pd_in), .oe_i(pd_oe),
    .data_i(pd_out));
  psp_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
    .slave_port_enable_i(en), .micro_mode_i(micro),
    .control_pin_direction_i({2'h3, dir_ok}), .strb_i(strb), .pd_in_i(pd_in),
    .pd_out_o(pd_out), .pd_oe_o(pd_oe), .fw_wr_i(fw_wr), .fw_wdata_i(fw_wd),
    .fw_rd_i(fw_rd), .fw_rdata_o(fw_rd_d), .fw_out_full_clr_i(of_clr),
    .fw_irq_clr_i(irq_clr), .flags_o(flags), .active_o(active), .rx_data_o(rx_d),
    .rx_valid_o(rx_v), .rx_ready_i(rdy));
  // -------------------------
  // clock, timeout, checks
  // -------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // hang guard, far above the expected run
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  // receive fifo drained under a random stall, against the model queue;
  // a pop only lands while the clock enable is high
  always @(posedge core_clk_i) begin
    rdy <= 1'($random(seed));
    if (rx_v === 1'b1 && rdy === 1'b1 && ce === 1'b1) chk(rx_d, q.pop_front());
  end
  // one-cycle firmware pulse: 0 latch write, 1 latch read, 2 output clear, 3 irq clear
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    case (k)
      0: fw_wr <= 1'b1;
      1: fw_rd <= 1'b1;
      2: of_clr <= 1'b1;
      default: irq_clr <= 1'b1;
    endcase
    @(posedge core_clk_i);
    {fw_wr, fw_rd, of_clr, irq_clr} <= 4'h0;
  endtask : pulse
  // -------------------------
  // main sequence
  // -------------------------
  initial begin
    {en, dir_ok, fw_wr, fw_rd, of_clr, irq_clr} = 6'h00;
    {micro, ce} = 2'h3;
    fw_wd = 8'h00;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    seed = 57437;
    rst_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    en <= 1'b1;
    dir_ok <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk(active, 1'b1);
    chk(flags, 3'h0);
    // six writes, each followed by a firmware read that clears the input flag
    for (int i = 0; i < 6; i++) begin
      b = 8'($random(seed));
      m.wr(b);
      q.push_back(b);
      repeat (6) @(posedge core_clk_i);
      chk(flags, 3'h5);
      pulse(1);
      pulse(3);
      @(posedge core_clk_i);
      chk(fw_rd_d, b);
      chk(flags, 3'h0);
    end
    $display("write test done");
    // firmware latch read by the master
    fw_wd <= 8'($random(seed));
    pulse(0);
    m.rd(got);
    chk(got, fw_wd);
    chk(flags.out_full, 1'b1);
    repeat (6) @(posedge core_clk_i);
    chk(pd_oe, 1'b0);
    chk(flags, 3'h3);
    // frozen clock enable: a clear pulse must not land
    ce <= 1'b0;
    pulse(3);
    chk(flags, 3'h3);
    ce <= 1'b1;
    pulse(2);
    pulse(3);
    @(posedge core_clk_i);
    chk(flags, 3'h0);
    // firmware write in mid-read shows on the pins, output flag stays low
    fork
      m.rd(got);
      begin
        fw_wd <= 8'($random(seed));
        repeat (3) @(posedge core_clk_i);
        pulse(2);
        pulse(0);
      end
    join
    chk(got, fw_wd);
    chk(flags.out_full, 1'b0);
    repeat (6) @(posedge core_clk_i);
    chk(flags, 3'h1);
    pulse(3);
    $display("read test done");
    // wrong pin direction, then external memory mode: writes ignored
    dir_ok <= 1'b0;
    m.wr(8'hA5);
    repeat (8) @(posedge core_clk_i);
    chk(flags, 3'h0);
    chk(active, 1'b0);
    dir_ok <= 1'b1;
    micro <= 1'b0;
    m.wr(8'h5A);
    repeat (8) @(posedge core_clk_i);
    chk(flags, 3'h0);
    chk(active, 1'b0);
    repeat (40) @(posedge core_clk_i);
    chk(8'(q.size()), 8'h00);
    $display("refusal and fifo test done");
    report_and_stop();
  end
endmodule : tb
